// ---- hw/dcr_pkg.sv ----
package dcr_pkg;
  localparam int          ADDR_W        = 10;
  localparam int          SAMPLE_W      = 16;
  localparam int          DAC_W         = 12;
  localparam int          DAC_CH        = 4;
  localparam int          QUEUE_DEPTH   = 48;
  localparam int          QPTR_W        = 6;
  localparam int          SYNC_W        = 27;
  localparam logic [3:0]  OFF_CMD       = 4'h0;
  localparam logic [3:0]  OFF_SAMPLE_HI = 4'h1;
  localparam logic [3:0]  OFF_SCAN_RNG  = 4'h2;
  localparam logic [3:0]  OFF_GAIN_STAT = 4'h3;
  localparam logic [3:0]  OFF_CONTROL   = 4'h4;
  localparam logic [3:0]  OFF_THRESHOLD = 4'h5;
  localparam logic [3:0]  OFF_DAC_LO    = 4'h6;
  localparam logic [3:0]  OFF_DAC_HI    = 4'h7;
  localparam logic [3:0]  OFF_PORT_A    = 4'h8;
  localparam logic [3:0]  OFF_PORT_B    = 4'h9;
  localparam logic [3:0]  OFF_PORT_C    = 4'ha;
  localparam logic [3:0]  OFF_PORT_DIR  = 4'hb;
  localparam logic [3:0]  OFF_CTR_B0    = 4'hc;
  localparam logic [3:0]  OFF_CTR_B1    = 4'hd;
  localparam logic [3:0]  OFF_CTR_B2    = 4'he;
  localparam logic [3:0]  OFF_CTR_CMD   = 4'hf;
  // command_trigger bit positions
  localparam int          CMD_START     = 7;
  localparam int          CMD_BOARD     = 6;
  localparam int          CMD_DAC       = 5;
  localparam int          CMD_QUEUE     = 4;
  localparam int          CMD_CLR_DMA   = 3;
  localparam int          CMD_CLR_TMR   = 2;
  localparam int          CMD_CLR_DIO   = 1;
  localparam int          CMD_CLR_ANA   = 0;
  // irq_dma_counter_control bit positions
  localparam int          CTL_AIE       = 0;
  localparam int          CTL_DIE       = 1;
  localparam int          CTL_TIE       = 2;
  localparam int          CTL_DMAE      = 3;
  localparam int          CTL_TRIG_SEL  = 4;
  localparam int          GAIN_SCAN_EN  = 2;
  localparam int          THR_W         = 6;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [11:0] DAC_MID       = 12'h800;
  localparam logic [11:0] DAC_ZERO      = 12'h000;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          SETTLE_NS     = 10000;
  localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_CNT_W  = 8;
  typedef enum logic { DCR_IDLE, DCR_BUSY } dcr_conv_state_t;
endpackage : dcr_pkg

// ---- hw/dcr_register_map.sv ----
`timescale 1ns/100ps
module dcr_register_map #(
  parameter logic [7:0] REVISION = 8'h01  // arbitrary value
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic [9:0]  i_base_addr,
  input  wire logic [9:0]  i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  output logic             o_io_rvalid,
  input  wire logic        i_single_ended,
  input  wire logic        i_dac_mid_scale,
  input  wire logic        i_ext_trig,
  input  wire logic [7:0]  i_port_a,
  input  wire logic [7:0]  i_port_b,
  input  wire logic [7:0]  i_port_c,
  input  wire logic        i_dac_busy,
  input  wire logic        i_ctr0_out,
  input  wire logic        i_timer_event,
  input  wire logic        i_dio_event,
  input  wire logic        i_dma_event,
  input  wire logic        i_conv_valid,
  input  wire logic [15:0] i_conv_data,
  output logic             o_conv_ready,
  output logic             o_conv_start,
  output logic      [3:0]  o_conv_channel,
  output logic      [1:0]  o_gain,
  output logic      [47:0] o_dac_values,
  output logic             o_dac_load,
  output logic      [7:0]  o_port_a,
  output logic      [7:0]  o_port_b,
  output logic      [7:0]  o_port_c,
  output logic      [7:0]  o_port_dir,
  output logic      [7:0]  o_control,
  output logic      [23:0] o_ctr_data,
  output logic      [7:0]  o_ctr_cmd,
  output logic             o_ctr_cmd_stb,
  output logic             o_board_reset,
  output logic             o_irq
);

  function automatic logic sel(input logic [3:0] a, input logic [3:0] off);
    sel = (a == off);
  endfunction : sel

  // bus decode
  logic [3:0] off;
  logic       hit;
  assign off = i_io_addr[3:0];
  assign hit = (i_io_addr[9:4] == i_base_addr[9:4]);
  logic       wr;
  logic       rd;
  assign wr = i_io_wr & hit;
  assign rd = i_io_rd & hit;

  // command decode; nothing here is stored
  logic       cmd_wr;
  logic [7:0] cmd;
  assign cmd_wr = wr & sel(off, dcr_pkg::OFF_CMD);
  assign cmd    = cmd_wr ? i_io_wdata : dcr_pkg::REG_RESET;
  logic       brd;
  assign brd = cmd[dcr_pkg::CMD_BOARD];

  // pin synchronisers
  logic [dcr_pkg::SYNC_W-1:0] sync1_reg;
  logic [dcr_pkg::SYNC_W-1:0] sync2_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {i_ext_trig, i_single_ended, i_dac_mid_scale, i_port_c, i_port_b, i_port_a};
      sync2_reg <= sync1_reg;
    end
  end
  logic       ext_trig_s;
  logic       se_s;
  logic       mid_s;
  logic [7:0] pin_a;
  logic [7:0] pin_b;
  logic [7:0] pin_c;
  assign {ext_trig_s, se_s, mid_s, pin_c, pin_b, pin_a} = sync2_reg;

  // plain registers written from the bus; the DAC low byte and port A/B/C outputs do not read back
  logic [7:0] scan_reg;
  logic [2:0] gain_reg;
  logic [7:0] ctl_reg;
  logic [5:0] thr_reg;
  logic [7:0] dac_lo_reg;
  logic [7:0] pa_reg;
  logic [7:0] pb_reg;
  logic [7:0] pc_reg;
  logic [7:0] dir_reg;
  logic [23:0] ctr_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn || brd) begin
      scan_reg   <= dcr_pkg::REG_RESET;
      gain_reg   <= '0;
      ctl_reg    <= dcr_pkg::REG_RESET;
      thr_reg    <= '0;
      dac_lo_reg <= dcr_pkg::REG_RESET;
      pa_reg     <= dcr_pkg::REG_RESET;
      pb_reg     <= dcr_pkg::REG_RESET;
      pc_reg     <= dcr_pkg::REG_RESET;
      dir_reg    <= dcr_pkg::REG_RESET;
      ctr_reg    <= '0;
    end else if (wr) begin
      if (sel(off, dcr_pkg::OFF_SCAN_RNG))  scan_reg   <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_GAIN_STAT)) gain_reg   <= i_io_wdata[2:0];
      if (sel(off, dcr_pkg::OFF_CONTROL))   ctl_reg    <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_THRESHOLD)) thr_reg    <= i_io_wdata[5:0];
      if (sel(off, dcr_pkg::OFF_DAC_LO))    dac_lo_reg <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_PORT_A))    pa_reg     <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_PORT_B))    pb_reg     <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_PORT_C))    pc_reg     <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_PORT_DIR))  dir_reg    <= i_io_wdata & 8'h9b;
      if (sel(off, dcr_pkg::OFF_CTR_B0))    ctr_reg[7:0]   <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_CTR_B1))    ctr_reg[15:8]  <= i_io_wdata;
      if (sel(off, dcr_pkg::OFF_CTR_B2))    ctr_reg[23:16] <= i_io_wdata;
    end
  end
  logic aie;
  logic scan_en;
  assign aie     = ctl_reg[dcr_pkg::CTL_AIE];
  assign scan_en = gain_reg[dcr_pkg::GAIN_SCAN_EN];

  // analog outputs survive board reset, only their own reset and i_rstn touch them
  logic dac_wr;
  logic dac_rst;
  assign dac_wr  = wr & sel(off, dcr_pkg::OFF_DAC_HI);
  assign dac_rst = cmd[dcr_pkg::CMD_DAC];
  genvar g;
  generate
    for (g = 0; g < dcr_pkg::DAC_CH; g++) begin : g_dac
      logic [11:0] val_reg;
      always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          val_reg <= dcr_pkg::DAC_ZERO;
        end else if (dac_rst) begin
          val_reg <= mid_s ? dcr_pkg::DAC_MID : dcr_pkg::DAC_ZERO;
        end else if (dac_wr && i_io_wdata[7:6] == 2'(g)) begin
          val_reg <= {i_io_wdata[3:0], dac_lo_reg};
        end
      end
      assign o_dac_values[g*12 +: 12] = val_reg;
    end
  endgenerate

  // settling timer after channel or gain change
  logic [dcr_pkg::SETTLE_CNT_W-1:0] settle_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn || brd) begin
      settle_reg <= '0;
    end else if (wr && (sel(off, dcr_pkg::OFF_SCAN_RNG) || sel(off, dcr_pkg::OFF_GAIN_STAT))) begin
      settle_reg <= dcr_pkg::SETTLE_CNT_W'(dcr_pkg::SETTLE_CYC);
    end else if (settle_reg != '0) begin
      settle_reg <= settle_reg - 1'b1;
    end
  end

  // two-entry buffer between converter and queue
  logic [15:0] buf_reg [2];
  logic [1:0]  buf_cnt_reg;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic        buf_push;
  logic        buf_pop;
  logic        ovf_reg;
  logic [5:0]  q_cnt_reg;
  assign o_conv_ready  = (buf_cnt_reg != 2'd2);
  assign buf_out_valid = (buf_cnt_reg != 2'd0);
  // an overflowed queue refuses words until reset, so the buffer backs up
  assign buf_out_ready = (q_cnt_reg != 6'(dcr_pkg::QUEUE_DEPTH)) & ~ovf_reg;
  assign buf_push      = i_conv_valid & o_conv_ready;
  assign buf_pop       = buf_out_valid & buf_out_ready;
  logic q_rst;
  assign q_rst = cmd[dcr_pkg::CMD_QUEUE] | brd;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      buf_cnt_reg <= '0;
      buf_reg[0]  <= '0;
      buf_reg[1]  <= '0;
    end else if (q_rst) begin
      buf_cnt_reg <= '0;
    end else begin
      if (buf_pop) buf_reg[0] <= buf_reg[1];
      if (buf_push && (buf_cnt_reg - 2'(buf_pop)) == 2'd0) buf_reg[0] <= i_conv_data;
      if (buf_push && (buf_cnt_reg - 2'(buf_pop)) == 2'd1) buf_reg[1] <= i_conv_data;
      buf_cnt_reg <= buf_cnt_reg + 2'(buf_push) - 2'(buf_pop);
    end
  end

  // sample queue
  logic [15:0] q_mem [dcr_pkg::QUEUE_DEPTH];
  logic [5:0]  q_wp_reg;
  logic [5:0]  q_rp_reg;
  logic        q_pop;
  logic [5:0]  q_cnt_next;
  assign q_pop      = rd & sel(off, dcr_pkg::OFF_SAMPLE_HI) & (q_cnt_reg != '0);
  assign q_cnt_next = q_cnt_reg + 6'(buf_pop) - 6'(q_pop);
  function automatic logic [5:0] wrap(input logic [5:0] p);
    wrap = (p == 6'(dcr_pkg::QUEUE_DEPTH - 1)) ? 6'd0 : p + 6'd1;
  endfunction : wrap
  always_ff @(posedge i_core_clk) begin
    if (buf_pop) q_mem[q_wp_reg] <= buf_reg[0];
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q_wp_reg  <= '0;
      q_rp_reg  <= '0;
      q_cnt_reg <= '0;
      ovf_reg   <= 1'b0;
    end else if (q_rst) begin
      q_wp_reg  <= '0;
      q_rp_reg  <= '0;
      q_cnt_reg <= '0;
      // a word dropped in the reset cycle still counts: set beats clear
      ovf_reg   <= i_conv_valid & ~o_conv_ready;
    end else begin
      if (buf_pop) q_wp_reg <= wrap(q_wp_reg);
      if (q_pop)   q_rp_reg <= wrap(q_rp_reg);
      q_cnt_reg <= q_cnt_next;
      if (i_conv_valid && !o_conv_ready) ovf_reg <= 1'b1;
    end
  end
  logic [15:0] head;
  assign head = q_mem[q_rp_reg];

  // conversion trigger
  logic src_sel;
  logic src_prev_reg;
  logic hw_trig;
  logic sw_trig;
  assign src_sel = ctl_reg[dcr_pkg::CTL_TRIG_SEL] ? ext_trig_s : i_ctr0_out;
  assign hw_trig = aie & src_sel & ~src_prev_reg;
  assign sw_trig = cmd[dcr_pkg::CMD_START] & ~aie;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) src_prev_reg <= 1'b0;
    else         src_prev_reg <= src_sel;
  end

  dcr_pkg::dcr_conv_state_t state_reg;
  dcr_pkg::dcr_conv_state_t state_next;
  logic [3:0] ch_reg;
  logic [3:0] ch_next;
  logic       start_next;
  logic       at_high;
  assign at_high = (ch_reg == scan_reg[7:4]);
  always_comb begin
    state_next = state_reg;
    start_next = 1'b0;
    case (state_reg)
      dcr_pkg::DCR_IDLE: begin
        if (sw_trig || hw_trig) begin
          state_next = dcr_pkg::DCR_BUSY;
          start_next = 1'b1;
        end
      end
      dcr_pkg::DCR_BUSY: begin
        if (i_conv_valid) begin
          if (scan_en && !at_high) begin
            start_next = 1'b1;
          end else begin
            state_next = dcr_pkg::DCR_IDLE;
          end
        end
      end
      default: state_next = dcr_pkg::DCR_IDLE;
    endcase
  end
  assign ch_next = at_high ? scan_reg[3:0] : ch_reg + 4'd1;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn || brd) begin
      state_reg    <= dcr_pkg::DCR_IDLE;
      o_conv_start <= 1'b0;
      ch_reg       <= '0;
    end else begin
      state_reg    <= state_next;
      o_conv_start <= start_next;
      if (wr && sel(off, dcr_pkg::OFF_SCAN_RNG)) ch_reg <= i_io_wdata[3:0];
      else if (state_reg == dcr_pkg::DCR_BUSY && i_conv_valid) ch_reg <= ch_next;
    end
  end
  logic active;
  assign active = (state_reg == dcr_pkg::DCR_BUSY);

  // interrupt request flip-flops: dma, timer, dio, analog; a set beats a clear
  logic [3:0] irq_reg;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic       ana_hit;
  assign ana_hit = (thr_reg != '0) & (q_cnt_next == thr_reg) & (q_cnt_reg != thr_reg);
  assign irq_set = {i_dma_event   & ctl_reg[dcr_pkg::CTL_DMAE],
                    i_timer_event & ctl_reg[dcr_pkg::CTL_TIE],
                    i_dio_event   & ctl_reg[dcr_pkg::CTL_DIE],
                    ana_hit       & aie};
  assign irq_clr = {cmd[dcr_pkg::CMD_CLR_DMA], cmd[dcr_pkg::CMD_CLR_TMR],
                    cmd[dcr_pkg::CMD_CLR_DIO], cmd[dcr_pkg::CMD_CLR_ANA]};
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn || brd) irq_reg <= '0;
    else                irq_reg <= irq_set | (irq_reg & ~irq_clr);
  end
  assign o_irq = |irq_reg;

  // read path
  logic [7:0] rd_mux;
  always_comb begin
    case (off)
      dcr_pkg::OFF_CMD:       rd_mux = head[7:0];
      dcr_pkg::OFF_SAMPLE_HI: rd_mux = head[15:8];
      dcr_pkg::OFF_SCAN_RNG:  rd_mux = scan_reg;
      dcr_pkg::OFF_GAIN_STAT: rd_mux = {active, se_s, settle_reg != '0, i_dac_busy,
                                        ovf_reg, gain_reg};
      dcr_pkg::OFF_CONTROL:   rd_mux = ctl_reg;
      dcr_pkg::OFF_THRESHOLD: rd_mux = {2'b00, thr_reg};
      dcr_pkg::OFF_DAC_LO:    rd_mux = {2'b00, q_cnt_reg};
      dcr_pkg::OFF_DAC_HI:    rd_mux = {irq_reg, ch_reg};
      dcr_pkg::OFF_PORT_A:    rd_mux = pin_a;
      dcr_pkg::OFF_PORT_B:    rd_mux = pin_b;
      dcr_pkg::OFF_PORT_C:    rd_mux = pin_c;
      dcr_pkg::OFF_PORT_DIR:  rd_mux = dir_reg;
      dcr_pkg::OFF_CTR_B0:    rd_mux = ctr_reg[7:0];
      dcr_pkg::OFF_CTR_B1:    rd_mux = ctr_reg[15:8];
      dcr_pkg::OFF_CTR_B2:    rd_mux = ctr_reg[23:16];
      default:                rd_mux = REVISION;
    endcase
  end

  logic ctr_cmd_wr;
  assign ctr_cmd_wr = wr & sel(off, dcr_pkg::OFF_CTR_CMD);
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata    <= '0;
      o_io_rvalid   <= 1'b0;
      o_dac_load    <= 1'b0;
      o_ctr_cmd     <= '0;
      o_ctr_cmd_stb <= 1'b0;
      o_board_reset <= 1'b0;
    end else begin
      o_io_rdata    <= rd ? rd_mux : 8'h00;
      o_io_rvalid   <= rd;
      o_dac_load    <= dac_wr | dac_rst;
      o_ctr_cmd_stb <= ctr_cmd_wr;
      if (ctr_cmd_wr) o_ctr_cmd <= i_io_wdata;
      o_board_reset <= brd;
    end
  end

  assign o_conv_channel = ch_reg;
  assign o_gain         = gain_reg[1:0];
  assign o_port_a       = pa_reg;
  assign o_port_b       = pb_reg;
  assign o_port_c       = pc_reg;
  assign o_port_dir     = dir_reg;
  assign o_control      = ctl_reg;
  assign o_ctr_data     = ctr_reg;

endmodule : dcr_register_map

// ---- tb/dcr_conv_model.sv ----
`timescale 1ns/100ps
module dcr_conv_model #(
  parameter int LATENCY = 5
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_start,
  input  wire logic [15:0] i_word,
  output logic             o_valid,
  output logic      [15:0] o_data,
  output int               o_starts
);
  int cnt_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg  <= 0;
      o_valid  <= 1'b0;
      o_data   <= 16'h0000;
      o_starts <= 0;
    end else begin
      if (i_start) begin
        cnt_reg  <= LATENCY;
        o_starts <= o_starts + 1;
      end else if (cnt_reg > 0) begin
        cnt_reg <= cnt_reg - 1;
      end
      o_valid <= (cnt_reg == 1);
      // outside the valid cycle the bus toggles so no stale word looks good
      o_data  <= (cnt_reg == 1) ? i_word : ~o_data;
    end
  end
endmodule : dcr_conv_model

// ---- tb/dcr_register_map_bench.sv ----
`timescale 1ns/100ps
module dcr_register_map_bench;
  // offset, write data, expected readback
  localparam logic [19:0] ROWS [9] = '{20'h2a5a5, 20'h4f0f0, 20'h5ff3f, 20'hbff9b,
    20'hc1212, 20'he5656, 20'h8003c, 20'h900c3, 20'hf815e};
  logic        clk;
  logic        rstn;
  logic [9:0]  base;
  logic [9:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic        ext_trig;
  logic        ctr0;
  logic [2:0]  ev;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        conv_valid;
  logic [15:0] conv_data;
  logic [15:0] conv_word;
  logic        conv_start;
  logic        conv_ready;
  logic        irq;
  logic [47:0] dac_values;
  logic [7:0]  port_dir;
  logic [1:0]  gain;
  logic [3:0]  channel;
  logic        mid;
  logic        busy;
  logic [7:0]  got;
  logic        ok;
  int          starts;
  int          s0;
  int          fails;
  int          comparisons;

  dcr_register_map #(.REVISION(8'h5e)) u_dut ( // arbitrary revision value
    .i_core_clk(clk), .i_rstn(rstn), .i_base_addr(base), .i_io_addr(addr),
    .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .o_io_rvalid(rvalid), .i_single_ended(1'b1), .i_dac_mid_scale(mid),
    .i_ext_trig(ext_trig), .i_port_a(8'h3c), .i_port_b(8'hc3), .i_port_c(8'h5a),
    .i_dac_busy(busy), .i_ctr0_out(ctr0), .i_timer_event(ev[0]), .i_dio_event(ev[1]),
    .i_dma_event(ev[2]), .i_conv_valid(conv_valid), .i_conv_data(conv_data),
    .o_conv_ready(conv_ready), .o_conv_start(conv_start), .o_conv_channel(channel),
    .o_gain(gain), .o_dac_values(dac_values), .o_dac_load(), .o_port_a(), .o_port_b(),
    .o_port_c(), .o_port_dir(port_dir), .o_control(), .o_ctr_data(), .o_ctr_cmd(),
    .o_ctr_cmd_stb(), .o_board_reset(), .o_irq(irq));

  dcr_conv_model u_conv (.i_core_clk(clk), .i_rstn(rstn),
    .i_start(conv_start), .i_word(conv_word), .o_valid(conv_valid),
    .o_data(conv_data), .o_starts(starts));

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  // far flips the window's low compare bit so the access misses the block
  task automatic bus_wr(input logic [3:0] off, input logic [7:0] d, input logic far = 1'b0);
    @(negedge clk);
    addr  = {base[9:4] ^ {5'h00, far}, off};
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] off, output logic [7:0] d, output logic v,
                        input logic far = 1'b0);
    @(negedge clk);
    addr = {base[9:4] ^ {5'h00, far}, off};
    rd   = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d  = rdata;
    v  = rvalid;
  endtask : bus_rd

  task automatic rd_reg(input logic [3:0] off, output logic [7:0] d);
    logic v;
    bus_rd(off, d, v);
    chk("rvalid", 16'h0001, 16'(v));
  endtask : rd_reg

  task automatic poll_idle();
    int n;
    n   = 0;
    got = 8'h80;
    while (got[7] !== 1'b0 && n < 40) begin
      rd_reg(dcr_pkg::OFF_GAIN_STAT, got);
      n++;
    end
    chk("status_idle", 16'h0000, 16'(got[7]));
  endtask : poll_idle

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    fails = 0;
    comparisons = 0;
    rstn = 1'b0;
    base = 10'h280;
    addr = 10'h000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    ext_trig = 1'b0;
    ctr0 = 1'b0;
    ev = 3'h0;
    conv_word = 16'h0000;
    mid = 1'b1;
    busy = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    chk("conv_ready", 16'h0001, 16'(conv_ready));
    rd_reg(dcr_pkg::OFF_CONTROL, got);
    chk("control_rst", 16'h0000, 16'(got));
    rd_reg(dcr_pkg::OFF_GAIN_STAT, got);
    chk("status_rst", 16'h0040, 16'(got & 8'hd8));
    busy = 1'b1;
    rd_reg(dcr_pkg::OFF_GAIN_STAT, got);
    busy = 1'b0;
    chk("dac_busy", 16'h0010, 16'(got & 8'h10));
    foreach (ROWS[i]) begin
      bus_wr(ROWS[i][19:16], ROWS[i][15:8]);
      rd_reg(ROWS[i][19:16], got);
      chk("row_readback", 16'(ROWS[i][7:0]), 16'(got));
    end
    bus_wr(dcr_pkg::OFF_CONTROL, 8'h0e, 1'b1);
    bus_rd(dcr_pkg::OFF_CONTROL, got, ok, 1'b1);
    chk("outside_rvalid", 16'h0000, 16'(ok));
    rd_reg(dcr_pkg::OFF_CONTROL, got);
    chk("outside_write", 16'h00f0, 16'(got));
    bus_wr(dcr_pkg::OFF_CONTROL, 8'h00);
    bus_wr(dcr_pkg::OFF_CMD, 8'h10);
    for (int i = 0; i < 2; i++) begin
      conv_word = (i == 0) ? 16'h8001 : 16'h1234;
      bus_wr(dcr_pkg::OFF_CMD, 8'h80);
      rd_reg(dcr_pkg::OFF_GAIN_STAT, got);
      chk("busy", 16'h0001, 16'(got[7]));
      poll_idle();
      if (i == 1) bus_wr(dcr_pkg::OFF_CMD, 8'h0f);
      rd_reg(dcr_pkg::OFF_CMD, got);
      chk("low_byte", 16'(conv_word[7:0]), 16'(got));
      rd_reg(dcr_pkg::OFF_SAMPLE_HI, got);
      chk("high_byte", 16'(conv_word[15:8]), 16'(got));
    end
    bus_wr(dcr_pkg::OFF_THRESHOLD, 8'h01);
    bus_wr(dcr_pkg::OFF_CONTROL, 8'h01);
    s0 = starts;
    bus_wr(dcr_pkg::OFF_CMD, 8'h80);
    wait_cyc(10);
    chk("sw_start_ignored", 16'(s0), 16'(starts));
    ctr0 = 1'b1;
    wait_cyc(3);
    ctr0 = 1'b0;
    wait_cyc(20);
    chk("counter_trigger", 16'(s0 + 1), 16'(starts));
    rd_reg(dcr_pkg::OFF_DAC_HI, got);
    chk("analog_flag", 16'h0010, 16'(got & 8'hf0));
    chk("irq_raised", 16'h0001, 16'(irq));
    bus_wr(dcr_pkg::OFF_CMD, 8'h01);
    chk("irq_cleared", 16'h0000, 16'(irq));
    bus_wr(dcr_pkg::OFF_CONTROL, 8'h11);
    ext_trig = 1'b1;
    wait_cyc(3);
    ext_trig = 1'b0;
    wait_cyc(20);
    chk("external_trigger", 16'(s0 + 2), 16'(starts));
    rd_reg(dcr_pkg::OFF_DAC_LO, got);
    chk("depth", 16'h0002, 16'(got));
    bus_wr(dcr_pkg::OFF_CMD, 8'h10);
    rd_reg(dcr_pkg::OFF_DAC_LO, got);
    chk("depth_reset", 16'h0000, 16'(got));
    bus_wr(dcr_pkg::OFF_CONTROL, 8'h0e);
    ev = 3'h7;
    @(negedge clk);
    ev = 3'h0;
    rd_reg(dcr_pkg::OFF_DAC_HI, got);
    chk("flags_set", 16'h00e0, 16'(got & 8'hf0));
    for (int i = 0; i < 3; i++) begin
      bus_wr(dcr_pkg::OFF_CMD, 8'h08 >> i);
      rd_reg(dcr_pkg::OFF_DAC_HI, got);
      chk("flag_clear", 16'((8'he0 >> (i + 1)) & 8'he0), 16'(got & 8'hf0));
    end
    chk("irq_idle", 16'h0000, 16'(irq));
    bus_wr(dcr_pkg::OFF_GAIN_STAT, 8'hfd);
    chk("gain_out", 16'h0001, 16'(gain));
    rd_reg(dcr_pkg::OFF_GAIN_STAT, got);
    chk("gain_settle", 16'h0025, 16'(got & 8'h3f));
    bus_wr(dcr_pkg::OFF_SCAN_RNG, 8'h31);
    chk("scan_low", 16'h0001, 16'(channel));
    s0 = starts;
    bus_wr(dcr_pkg::OFF_CMD, 8'h80);
    poll_idle();
    chk("scan_starts", 16'(s0 + 3), 16'(starts));
    chk("scan_wrap", 16'h0001, 16'(channel));
    rd_reg(dcr_pkg::OFF_DAC_LO, got);
    chk("scan_depth", 16'h0003, 16'(got));
    bus_wr(dcr_pkg::OFF_DAC_LO, 8'h34);
    bus_wr(dcr_pkg::OFF_DAC_HI, 8'h4a);
    chk("dac_ch1", 16'h0a34, 16'(dac_values[23:12]));
    ev = 3'h1;
    @(negedge clk);
    ev = 3'h0;
    bus_wr(dcr_pkg::OFF_PORT_DIR, 8'h9b);
    bus_wr(dcr_pkg::OFF_CMD, 8'h40);
    chk("dac_kept", 16'h0a34, 16'(dac_values[23:12]));
    chk("dir_input", 16'h0000, 16'(port_dir));
    chk("irq_halted", 16'h0000, 16'(irq));
    rd_reg(dcr_pkg::OFF_THRESHOLD, got);
    chk("threshold_rst", 16'h0000, 16'(got));
    bus_wr(dcr_pkg::OFF_CMD, 8'h20);
    wait_cyc(1);
    for (int i = 0; i < 4; i++) begin
      chk("dac_mid", 16'h0800, 16'(dac_values[12*i +: 12]));
    end
    mid = 1'b0;
    wait_cyc(5);
    bus_wr(dcr_pkg::OFF_CMD, 8'h20);
    wait_cyc(1);
    chk("dac_zero", 16'h0000, 16'(|dac_values));
    summarize();
  end
endmodule : dcr_register_map_bench

// ---- tb/dcr_register_map_props.sv ----
`timescale 1ns/100ps
module dcr_register_map_props (
  input wire logic        i_core_clk,
  input wire logic        i_rstn,
  input wire logic [9:0]  i_base_addr,
  input wire logic [9:0]  i_io_addr,
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic [7:0]  i_io_wdata,
  input wire logic        i_dac_mid_scale,
  input wire logic        o_io_rvalid,
  input wire logic [47:0] o_dac_values,
  input wire logic        o_dac_load,
  input wire logic [7:0]  o_port_a,
  input wire logic [7:0]  o_port_dir,
  input wire logic [7:0]  o_control,
  input wire logic [23:0] o_ctr_data,
  input wire logic [7:0]  o_ctr_cmd,
  input wire logic        o_ctr_cmd_stb,
  input wire logic        o_board_reset,
  input wire logic        o_conv_start,
  input wire logic        o_irq
);
  logic        in_win;
  logic        cmd_wr;
  logic        bd_cmd;
  logic        ctr_wr;
  logic [47:0] dac_rst_val;
  assign in_win      = i_io_addr[9:4] == i_base_addr[9:4];
  assign cmd_wr      = i_io_wr && in_win && (i_io_addr[3:0] == dcr_pkg::OFF_CMD);
  assign bd_cmd      = cmd_wr && i_io_wdata[dcr_pkg::CMD_BOARD];
  assign ctr_wr      = i_io_wr && in_win && (i_io_addr[3:0] == dcr_pkg::OFF_CTR_CMD);
  assign dac_rst_val = i_dac_mid_scale ? {4{dcr_pkg::DAC_MID}} : {4{dcr_pkg::DAC_ZERO}};
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  a_read_answer: assert property (i_io_rd && in_win |=> o_io_rvalid)
    else $error("in-window read gave no rvalid");
  a_read_outside: assert property (i_io_rd && !in_win |=> !o_io_rvalid)
    else $error("out-of-window read answered");
  a_board_pulse: assert property (o_board_reset == $past(bd_cmd))
    else $error("board reset pulse not tied to command");
  a_board_clears: assert property (bd_cmd && !i_io_wdata[5] |=>
    o_port_dir == 8'h00 && o_control == 8'h00 && o_ctr_data == 24'h000000
    && $stable(o_dac_values)) else $error("board reset left state behind");
  // sync delay of the strap: only judge when it has been steady for a while
  a_dac_reset: assert property (cmd_wr && i_io_wdata[5] && $past(i_rstn, 4)
    && i_dac_mid_scale == $past(i_dac_mid_scale, 4) |=> o_dac_values == dac_rst_val
    ##[0:1] o_dac_load) else $error("analog output reset wrong");
  a_irq_holds: assert property (o_irq && !i_io_wr |=> o_irq)
    else $error("interrupt dropped without a clear");
  a_ctr_strobe: assert property (ctr_wr |=> o_ctr_cmd_stb && o_ctr_cmd == $past(i_io_wdata))
    else $error("counter command not forwarded");
  a_outside_write: assert property (i_io_wr && !in_win |=> $stable(o_port_a)
    && $stable(o_port_dir) && $stable(o_control) && !o_ctr_cmd_stb && !o_board_reset)
    else $error("out-of-window write had effect");
  a_dir_unused: assert property ((o_port_dir & 8'h64) == 8'h00)
    else $error("unused direction bits set");
  c_start: cover property (o_conv_start);
  c_board: cover property (bd_cmd);
  c_irq: cover property ($rose(o_irq));
  c_read: cover property (o_io_rvalid);
endmodule : dcr_register_map_props

bind dcr_register_map dcr_register_map_props u_props (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_base_addr(i_base_addr),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .i_dac_mid_scale(i_dac_mid_scale), .o_io_rvalid(o_io_rvalid),
  .o_dac_values(o_dac_values), .o_dac_load(o_dac_load), .o_port_a(o_port_a),
  .o_port_dir(o_port_dir), .o_control(o_control), .o_ctr_data(o_ctr_data),
  .o_ctr_cmd(o_ctr_cmd), .o_ctr_cmd_stb(o_ctr_cmd_stb), .o_board_reset(o_board_reset),
  .o_conv_start(o_conv_start), .o_irq(o_irq)
);
